// ---- logic/pwm_ctrl_defines.svh ----
// offsets, field positions, reset values and timing counts
`ifndef PWM_CTRL_DEFINES_SVH
`define PWM_CTRL_DEFINES_SVH
// staging and dummy register addresses
`define ADDR_STAGE0 3'h0
`define ADDR_STAGE1 3'h1
`define ADDR_STAGE2 3'h2
`define ADDR_CTRL_COMMIT 3'h3
`define ADDR_INIT_COMMIT 3'h4
// control word fields (24 bits: stage2,stage1,stage0)
`define CW_PFS_LO_LSB 0
`define CW_PFS_LO_MSB 7
`define CW_PFS_HI_LSB 8
`define CW_PFS_HI_MSB 11
`define CW_OVERMOD 12
`define CW_INHIBIT_N 13
`define CW_AMP_LSB 16
`define CW_AMP_MSB 23
// init word fields
`define IW_DELETE_LSB 0
`define IW_DELETE_MSB 6
`define IW_CLEAR_N 7
`define IW_CDS_LSB 8
`define IW_CDS_MSB 10
`define IW_FRM_LSB 11
`define IW_FRM_MSB 13
`define IW_UNDERLAP_LSB 16
`define IW_UNDERLAP_MSB 21
// reset values
`define WORD_RESET 24'h000000
`define BYTE_RESET 8'h00
// carrier period in clock ticks before division
`define CARRIER_TICKS 512
`define SINE_PERIOD_SAMPLES 384
`endif

// ---- logic/pwm_ctrl_pkg.sv ----
// types for the pwm control word logic
package pwm_ctrl_pkg;
    typedef logic [23:0] word24_t;
    typedef logic [7:0] byte_t;
    typedef logic [11:0] pfs_t;
endpackage : pwm_ctrl_pkg

// ---- logic/param_if.sv ----
// committed parameters passed from the register file to the waveform
`timescale 1ns/1ps
interface param_if;
    logic [11:0] pfs;
    logic overmod;
    logic inhibit_n;
    logic [7:0] amp;
    logic [6:0] delete_word;
    logic clear_n;
    logic [2:0] cds;
    logic [2:0] frm;
    logic [5:0] underlap_word;
    modport src (output pfs, overmod, inhibit_n, amp, delete_word, clear_n,
                 cds, frm, underlap_word);
    modport dst (input pfs, overmod, inhibit_n, amp, delete_word, clear_n,
                 cds, frm, underlap_word);
endinterface : param_if

// ---- logic/stage_regs.sv ----
// staging registers with atomic commit into control and init words
`timescale 1ns/1ps
`include "pwm_ctrl_defines.svh"
module stage_regs (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // host write port
    input wire logic wr_en,
    input wire logic [2:0] wr_addr,
    input wire logic [7:0] wr_data,
    // committed parameters
    param_if.src prm
);
    pwm_ctrl_pkg::byte_t stage_reg [3];
    pwm_ctrl_pkg::word24_t ctrl_reg;
    pwm_ctrl_pkg::word24_t init_reg;
    pwm_ctrl_pkg::word24_t stage_word;
    wire ctrl_hit = wr_en && (wr_addr == `ADDR_CTRL_COMMIT);
    wire init_hit = wr_en && (wr_addr == `ADDR_INIT_COMMIT);
    assign stage_word = {stage_reg[2], stage_reg[1], stage_reg[0]};

    // ****************************************
    // staging bytes, kept after commit
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_stage
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n)
                    stage_reg[gi] <= `BYTE_RESET;
                else if (wr_en && wr_addr == 3'(gi))
                    stage_reg[gi] <= wr_data;
            end
        end
    endgenerate

    // ****************************************
    // commit words
    // ****************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= `WORD_RESET;
            init_reg <= `WORD_RESET;
        end else begin
            if (ctrl_hit)
                ctrl_reg <= stage_word;
            if (init_hit)
                init_reg <= stage_word;
        end
    end

    assign prm.pfs = {ctrl_reg[`CW_PFS_HI_MSB:`CW_PFS_HI_LSB],
                      ctrl_reg[`CW_PFS_LO_MSB:`CW_PFS_LO_LSB]};
    assign prm.overmod = ctrl_reg[`CW_OVERMOD];
    assign prm.inhibit_n = ctrl_reg[`CW_INHIBIT_N];
    assign prm.amp = ctrl_reg[`CW_AMP_MSB:`CW_AMP_LSB];
    assign prm.delete_word = init_reg[`IW_DELETE_MSB:`IW_DELETE_LSB];
    assign prm.clear_n = init_reg[`IW_CLEAR_N];
    assign prm.cds = init_reg[`IW_CDS_MSB:`IW_CDS_LSB];
    assign prm.frm = init_reg[`IW_FRM_MSB:`IW_FRM_LSB];
    assign prm.underlap_word =
        init_reg[`IW_UNDERLAP_MSB:`IW_UNDERLAP_LSB];
endmodule : stage_regs

// ---- logic/amp_scale.sv ----
// scales a waveform sample by the nine-bit amplitude
`timescale 1ns/1ps
module amp_scale (
    // inputs
    input wire logic [7:0] sample,
    input wire logic [7:0] amp,
    input wire logic overmod,
    // scaled result, full scale is 255*255
    output logic [16:0] scaled
);
    wire [8:0] amp9 = {overmod, amp};
    wire [16:0] prod = 17'(sample) * 17'(amp9);
    // overmod adds a full-scale sample on top: amplitude plus 100 percent
    wire [16:0] full = 17'(sample) * 17'h000ff;
    assign scaled = overmod ? 17'(prod - 17'(sample) * 17'h00100 + full)
                            : prod;
endmodule : amp_scale

// ---- logic/pwm_control_word_logic.sv ----
// top: staging registers, phase accumulator, carrier and pulse shaping
//
// Summary of operation
// - power frequency equals range over 4096 times select word
// - select word split over staging registers zero and one
// - inhibit low forces outputs low, internal generation keeps running
// - outputs resume immediately when inhibit released
// - inhibit gating sits after deletion and delay stages
// - overmod bit acts as ninth amplitude bit
// - overmod amplitude equals normal amplitude plus 100 percent
// - waveform sample scaled by eight-bit amplitude word
// - amplitude percentage is value over 255 times 100
// - init and control registers clear to zero at power-up
// - counter clear low at reset gives 50 percent duty
// - carrier division select taken from staging register one
// - range multiplier taken from staging register one
// - underlap delay taken from staging register two
// - deletion field taken from staging register zero
// - shortest pulse is deletion time minus underlap time
// - control commit copies staging into control register
// - init commit copies staging into init register
// - counter clear low holds phase at zero, ignores frequency
`timescale 1ns/1ps
`include "pwm_ctrl_defines.svh"
module pwm_control_word_logic (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // host write port
    input wire logic wr_en,
    input wire logic [2:0] wr_addr,
    input wire logic [7:0] wr_data,
    // waveform sample lookup
    output logic [8:0] sample_index,
    input wire logic [7:0] sample_data,
    // pwm outputs
    output logic pwm_top,
    output logic pwm_bottom,
    // status
    output logic [11:0] phase_out
);
    param_if prm ();

    // ****************************************
    // register file
    // ****************************************
    stage_regs u_regs (
        .mclk(mclk),
        .reset_n(reset_n),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .prm(prm)
    );

    // ****************************************
    // carrier prescaler: n = 2^cds for cds 0..5, n = 32 for cds 6 and 7
    // ****************************************
    logic [4:0] pre_reg;
    logic [4:0] pre_next;
    wire [4:0] pre_max = 5'((6'h01 << prm.cds) - 6'h01);
    wire pre_tick = (pre_reg >= pre_max);
    assign pre_next = pre_tick ? 5'h00 : 5'(pre_reg + 5'h01);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            pre_reg <= 5'h00;
        else
            pre_reg <= pre_next;
    end

    // ****************************************
    // carrier triangle counter, 512 ticks per period
    // ****************************************
    logic [8:0] car_reg;
    logic [8:0] car_next;
    assign car_next = pre_tick ? 9'(car_reg + 9'h001) : car_reg;
    wire [7:0] tri_val = car_reg[8] ? ~car_reg[7:0] : car_reg[7:0];
    wire car_wrap = pre_tick && (car_reg == 9'h1ff);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            car_reg <= 9'h000;
        else
            car_reg <= car_next;
    end

    // ****************************************
    // phase accumulator
    // ****************************************
    // per carrier period add 4*pfs*m; full cycle = 1536*4096
    // so full select at m=1 gives 384 carrier periods per cycle
    logic [23:0] acc_reg;
    logic [23:0] acc_next;
    localparam logic [23:0] acc_wrap = 24'h600000;
    wire [20:0] step = {7'h00, prm.pfs, 2'b00} << prm.frm;
    wire [24:0] acc_sum = 25'(acc_reg) + 25'(step);
    wire [24:0] acc_red = (acc_sum >= 25'(acc_wrap)) ?
                          25'(acc_sum - 25'(acc_wrap)) : acc_sum;
    assign acc_next = !prm.clear_n ? 24'h000000 :
                      car_wrap ? acc_red[23:0] : acc_reg;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            acc_reg <= 24'h000000;
        else
            acc_reg <= acc_next;
    end

    // quarter-wave fold: phase index 0..1535 in units of samples
    wire [10:0] ph = acc_reg[22:12];
    wire [1:0] quad = (ph < 11'd384) ? 2'd0 : (ph < 11'd768) ? 2'd1 :
                      (ph < 11'd1152) ? 2'd2 : 2'd3;
    wire [10:0] qoff = 11'(ph - 11'(quad) * 11'd384);
    wire [8:0] idx = quad[0] ? 9'(11'd383 - qoff) : qoff[8:0];
    wire neg_half = quad[1];

    // ****************************************
    // amplitude and comparison
    // ****************************************
    logic [16:0] scaled;
    amp_scale u_amp (
        .sample(sample_data),
        .amp(prm.amp),
        .overmod(prm.overmod),
        .scaled(scaled)
    );
    // modulating level: 0..255 per half; /256 of 255*255 range
    wire [8:0] mag = 9'(scaled >> 8);
    wire [9:0] lvl = neg_half ? 10'(10'sd255 - 10'(mag)) :
                     10'(10'd255 + 10'(mag));
    // negative half may underflow with overmod: clip to zero, not full
    wire lvl_under = neg_half && (mag > 9'd255);
    wire [9:0] lvl_clip = lvl_under ? 10'h000 : lvl[9] ? 10'h1fe : lvl;
    // clear low: level fixed at midpoint for 50 percent duty
    wire [9:0] lvl_use = !prm.clear_n ? 10'h0ff : lvl_clip;
    wire raw_pwm = ({1'b0, tri_val, 1'b0} < lvl_use);

    // ****************************************
    // pulse deletion
    // ****************************************
    logic raw_reg;
    logic del_reg;
    logic [7:0] width_reg;
    wire [7:0] pdt = 8'd128 - 8'(prm.delete_word);
    wire edge_seen = (raw_pwm != raw_reg);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            raw_reg <= 1'b0;
            del_reg <= 1'b0;
            width_reg <= 8'h00;
        end else if (pre_tick) begin
            raw_reg <= raw_pwm;
            if (edge_seen)
                width_reg <= 8'h01;
            else if (width_reg != 8'hff)
                width_reg <= 8'(width_reg + 8'h01);
            // a level passes once it has lasted the deletion time
            if (width_reg >= pdt)
                del_reg <= raw_reg;
        end
    end

    // ****************************************
    // underlap delay on rising and falling edges
    // ****************************************
    logic [6:0] dly_reg;
    logic del_q_reg;
    wire [6:0] pdy = 7'd64 - 7'(prm.underlap_word);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dly_reg <= 7'h00;
            del_q_reg <= 1'b0;
        end else if (pre_tick) begin
            del_q_reg <= del_reg;
            if (del_reg != del_q_reg)
                dly_reg <= 7'h00;
            else if (dly_reg != 7'h7f)
                dly_reg <= 7'(dly_reg + 7'h01);
        end
    end
    // delay follows deletion, so shortest pulse is pdt minus pdy
    wire dly_ok = (dly_reg >= pdy) && (del_reg == del_q_reg);
    wire top_pre = del_reg && dly_ok;
    wire bot_pre = !del_reg && dly_ok;

    // ****************************************
    // output gating after shaping
    // ****************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_top <= 1'b0;
            pwm_bottom <= 1'b0;
            sample_index <= 9'h000;
            phase_out <= 12'h000;
        end else begin
            pwm_top <= top_pre && prm.inhibit_n;
            pwm_bottom <= bot_pre && prm.inhibit_n;
            sample_index <= idx;
            phase_out <= acc_reg[23:12];
        end
    end
endmodule : pwm_control_word_logic

// ---- sim/pwm_ctrl_monitor.sv ----
// assertion checker for the pwm control word logic
`timescale 1ns/1ps
module pwm_ctrl_monitor (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // host write port
    input wire logic wr_en,
    input wire logic [2:0] wr_addr,
    input wire logic [7:0] wr_data,
    // watched outputs
    input wire logic [8:0] sample_index,
    input wire logic pwm_top,
    input wire logic pwm_bottom,
    input wire logic [11:0] phase_out
);
    // ****************************************
    // shadow of committed fields
    // ****************************************
    logic [7:0] s0_reg, s1_reg;
    logic inh_reg, clr_reg;
    logic [2:0] cds_reg, frm_reg;
    logic [11:0] pfs_reg, prev_reg;
    logic [9:0] hold_reg;
    wire ctl_wr = wr_en && wr_addr == 3'h3;
    wire ini_wr = wr_en && wr_addr == 3'h4;
    // moving fast enough to step the phase output every carrier period
    wire moving = clr_reg && cds_reg == 3'h0 &&
        (({7'h00, pfs_reg} << frm_reg) >= 19'd1024);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s0_reg <= 8'h00;
            s1_reg <= 8'h00;
            inh_reg <= 1'b0;
            clr_reg <= 1'b0;
            cds_reg <= 3'h0;
            frm_reg <= 3'h0;
            pfs_reg <= 12'h000;
            prev_reg <= 12'h000;
            hold_reg <= 10'h000;
        end else begin
            s0_reg <= (wr_en && wr_addr == 3'h0) ? wr_data : s0_reg;
            s1_reg <= (wr_en && wr_addr == 3'h1) ? wr_data : s1_reg;
            inh_reg <= ctl_wr ? s1_reg[5] : inh_reg;
            pfs_reg <= ctl_wr ? {s1_reg[3:0], s0_reg} : pfs_reg;
            clr_reg <= ini_wr ? s0_reg[7] : clr_reg;
            cds_reg <= ini_wr ? s1_reg[2:0] : cds_reg;
            frm_reg <= ini_wr ? s1_reg[5:3] : frm_reg;
            prev_reg <= phase_out;
            hold_reg <= (moving && phase_out == prev_reg) ?
                hold_reg + 10'h001 : 10'h000;
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    sequence ctl_commit_s; ctl_wr && !s1_reg[5]; endsequence
    sequence quiet_s; !pwm_top && !pwm_bottom; endsequence
    inhibit_low_a: assert property (!inh_reg |=> quiet_s)
        else $error("outputs active under inhibit");
    commit_gate_a: assert property (ctl_commit_s |-> ##2 quiet_s)
        else $error("commit did not gate outputs");
    no_overlap_a: assert property (!(pwm_top && pwm_bottom))
        else $error("both switches on");
    clear_phase_a: assert property ((!clr_reg) [*2] |=>
        phase_out == 12'h000) else $error("phase not held at zero");
    freq_stop_a: assert property ((clr_reg && pfs_reg == 12'h000) [*3]
        |=> $stable(phase_out)) else $error("phase moves at zero select");
    freq_run_a: assert property (moving |-> hold_reg < 10'd600)
        else $error("phase stalled");
    resume_a: assert property ($rose(inh_reg) && cds_reg == 3'h0
        |-> ##[1:600] (pwm_top || pwm_bottom)) else $error("no resume");
    index_range_a: assert property (sample_index <= 9'd383)
        else $error("sample index out of range");
endmodule : pwm_ctrl_monitor

// ---- sim/sample_rom_model.sv ----
// waveform sample store seen at the lookup port
`timescale 1ns/1ps
module sample_rom_model (
    // lookup
    input wire logic [8:0] sample_index,
    output logic [7:0] sample_data
);
    // full scale samples; beyond the quarter wave reads zero
    assign sample_data = (sample_index < 9'd384) ? 8'hff : 8'h00;
endmodule : sample_rom_model

// ---- sim/tb_pwm_control_word_logic.sv ----
// self-checking bench for the pwm control word logic
`timescale 1ns/1ps
module tb_pwm_control_word_logic;
    typedef struct {
        logic [11:0] pfs;
        logic om;
        logic [7:0] amp;
        int len;
        logic [11:0] ph_exp, ph_tol, top_exp, top_tol;
    } row_t;
    row_t rows [7] = '{
        '{12'h000, 1'b0, 8'h00, 3072, 12'h000, 12'h004, 12'h600, 12'h040},
        '{12'h010, 1'b0, 8'h00, 3072, 12'h006, 12'h001, 12'h600, 12'h040},
        '{12'h03f, 1'b0, 8'h00, 3072, 12'h018, 12'h001, 12'h600, 12'h040},
        '{12'hfff, 1'b0, 8'h00, 1024, 12'h200, 12'h001, 12'h200, 12'h040},
        '{12'h000, 1'b0, 8'h80, 3072, 12'h000, 12'h004, 12'h903, 12'h040},
        '{12'h000, 1'b0, 8'hff, 3072, 12'h000, 12'h004, 12'hc00, 12'h040},
        '{12'h000, 1'b1, 8'h00, 3072, 12'h000, 12'h004, 12'hc00, 12'h040}};
    logic mclk, reset_n, wr_en, pwm_top, pwm_bottom;
    logic [2:0] wr_addr;
    logic [7:0] wr_data, sample_data, b1;
    logic [8:0] sample_index;
    logic [11:0] phase_out, top_cnt, any_cnt, dph;
    int num_errors = 0;
    int comparisons = 0;
    pwm_control_word_logic i_pwm_control_word_logic (.mclk(mclk),
        .reset_n(reset_n), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .sample_index(sample_index),
        .sample_data(sample_data), .pwm_top(pwm_top),
        .pwm_bottom(pwm_bottom), .phase_out(phase_out));
    sample_rom_model i_sample_rom_model (.sample_index(sample_index),
        .sample_data(sample_data));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic load(input logic [7:0] b0, bb, b2, input logic [2:0] c);
        wr(3'h0, b0);
        wr(3'h1, bb);
        wr(3'h2, b2);
        wr(c, 8'h00);
    endtask : load
    task automatic meas(input int n);
        logic [11:0] p0;
        @(negedge mclk);
        p0 = phase_out;
        top_cnt = 12'h000;
        any_cnt = 12'h000;
        repeat (n) begin
            @(negedge mclk);
            top_cnt = top_cnt + {11'h000, pwm_top === 1'b1};
            any_cnt = any_cnt + {11'h000, {pwm_top, pwm_bottom} !== 2'b00};
        end
        dph = phase_out - p0;
    endtask : meas
    task automatic cmp_near(input logic [11:0] got, exp, tol);
        logic [11:0] d;
        d = got - exp;
        if (d[11] === 1'b1) begin
            d = -d;
        end
        comparisons++;
        if ((^got === 1'bx) || d > tol) begin
            num_errors++;
            $display("CHECK FAILED %0t got %0d exp %0d", $time, got, exp);
        end
    endtask : cmp_near
    task automatic cmp_bits(input logic [13:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_bits
    task automatic complete_run;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        reset_n = 1'b0;
        wr_en = 1'b0;
        wr_addr = 3'h0;
        wr_data = 8'h00;
        repeat (3) @(posedge mclk);
        cmp_bits({pwm_top, pwm_bottom, phase_out}, 14'h0000);
        reset_n <= 1'b1;
        meas(600);
        cmp_near(any_cnt, 12'h000, 12'h000);
        cmp_near(dph, 12'h000, 12'h000);
        foreach (rows[i]) begin
            b1 = {2'b00, 1'b1, rows[i].om, rows[i].pfs[11:8]};
            load(rows[i].pfs[7:0], b1, rows[i].amp, 3'h3);
            load(8'h7f, 8'h30, 8'h3f, 3'h4);
            wr(3'h0, 8'hff);
            wr(3'h4, 8'h00);
            meas(rows[i].len);
            cmp_near(dph, rows[i].ph_exp, rows[i].ph_tol);
            cmp_near(top_cnt, rows[i].top_exp, rows[i].top_tol);
        end
        for (int a = 5; a < 8; a++) begin
            wr(3'(a), 8'h00);
        end
        meas(512);
        cmp_near(top_cnt, 12'h200, 12'h010);
        load(8'h10, 8'h00, 8'h00, 3'h3);
        meas(3072);
        cmp_near(any_cnt, 12'h000, 12'h000);
        cmp_near(dph, 12'h006, 12'h001);
        wr(3'h1, 8'h20);
        wr(3'h3, 8'h00);
        meas(512);
        cmp_near(top_cnt, 12'h100, 12'h046);
        @(posedge mclk);
        reset_n <= 1'b0;
        @(negedge mclk);
        cmp_bits({pwm_top, pwm_bottom, phase_out}, 14'h0000);
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        load(8'h10, 8'h20, 8'h80, 3'h3);
        // let the power-up deletion and delay settle for one period
        meas(512);
        meas(3072);
        cmp_near(top_cnt, 12'h480, 12'h010);
        cmp_near(any_cnt, 12'h900, 12'h010);
        cmp_near(dph, 12'h000, 12'h000);
        complete_run();
    end
endmodule : tb_pwm_control_word_logic
bind pwm_control_word_logic pwm_ctrl_monitor i_pwm_ctrl_monitor (
    .mclk(mclk), .reset_n(reset_n), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .sample_index(sample_index), .pwm_top(pwm_top),
    .pwm_bottom(pwm_bottom), .phase_out(phase_out));
